// ---- hdl/fbwrm_pkg.sv ----
// constants and carrier types for the bus-width and rate matcher
// assumes one 125 MHz clock; double-rate ports are modelled as two slots per cycle
`default_nettype none
package fbwrm_pkg;
    // ******************************************************************
    // register map (byte addresses on a 32-bit apb)
    // ******************************************************************
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_MASK   = 12'h004;
    localparam logic [11:0] OFF_THRESH = 12'h008;
    localparam logic [11:0] OFF_LEVEL  = 12'h00C;
    localparam int          AW         = 12;
    localparam int          DW         = 32;

    // ******************************************************************
    // field layout and reset values
    // ******************************************************************
    localparam int          EV_FULL        = 0;
    localparam int          EV_EMPTY       = 1;
    localparam int          EV_REFUSED     = 2;
    localparam int          EV_ALMOST_FULL = 3;
    localparam int          EV_W           = 4;
    localparam int          TH_AE_LSB      = 0;
    localparam int          TH_AF_LSB      = 8;
    localparam int          TH_W           = 8;
    localparam int          LV_FLAGS_LSB   = 16;
    localparam int          LV_CFG_LSB     = 20;
    localparam logic [3:0]  MASK_RESET     = 4'h0;
    localparam logic [7:0]  AE_RESET       = 8'h02;
    localparam logic [7:0]  AF_RESET       = 8'h02;

    // ******************************************************************
    // data layout
    // ******************************************************************
    localparam int          HALF_W     = 10;
    localparam int          WORD_W     = 20;
    localparam int          MAX_HALVES = 4;
    localparam int          SYNC_DEPTH = 2;

    // register decode result
    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_STAT = 3'h1,
        REG_MASK = 3'h2,
        REG_THR  = 3'h3,
        REG_LVL  = 3'h4
    } fbwrm_reg_e;

    // port configuration; high means double rate or 10-bit wide
    typedef struct packed {
        logic wrDouble;
        logic rdDouble;
        logic inNarrow;
        logic outNarrow;
    } fbwrm_cfg_s;

    // word0 is the rising-edge slot, word1 the falling-edge slot
    typedef struct packed {
        logic [WORD_W-1:0] word1;
        logic [WORD_W-1:0] word0;
    } fbwrm_words_s;

    // live flag levels
    typedef struct packed {
        logic almostFull;
        logic full;
        logic almostEmpty;
        logic empty;
    } fbwrm_flags_s;
endpackage : fbwrm_pkg
`default_nettype wire

// ---- hdl/fbwrm_rate_matcher.sv ----
// bus-width and rate matcher: packs or splits 20/10-bit words between ports
// assumes write and read logic share clk; config pins and master reset are
// asynchronous pins and are synchronised here; software reaches it over apb
//
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none
module fbwrm_rate_matcher #(
    parameter int DEPTH = 32
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  clkEn,
    input  wire logic                  masterResetIn,
    input  wire logic                  writeRateSelect,
    input  wire logic                  readRateSelect,
    input  wire logic                  inputWidthSelect,
    input  wire logic                  outputWidthSelect,
    input  wire logic                  wrValid,
    output logic                       wrReady,
    input  wire fbwrm_pkg::fbwrm_words_s wrWords,
    output logic                       rdValid,
    input  wire logic                  rdReady,
    output fbwrm_pkg::fbwrm_words_s    rdWords,
    output logic                       emptyFlagOut,
    output logic                       almostEmptyFlag,
    output logic                       fullFlagOut,
    output logic                       almostFullFlag,
    output logic                       irq,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    // pointers wrap by the depth and the level field holds nine count bits
    if (DEPTH < 2 * fbwrm_pkg::MAX_HALVES || DEPTH > 256 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_depthCheck
        $error("DEPTH must be a power of two from 8 to 256");
    end

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic [4:0]            pinMeta;
    logic [4:0]            pinSync;
    logic [4:0]            next_pinMeta;
    logic [4:0]            next_pinSync;
    fbwrm_pkg::fbwrm_cfg_s cfgPins;
    logic                  mrsActive;

    // only the second flop reads the first
    always_comb begin
        next_pinMeta = {masterResetIn, writeRateSelect, readRateSelect,
                        inputWidthSelect, outputWidthSelect};
        next_pinSync = pinMeta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
        end else if (clkEn) begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
        end
    end

    // master reset pin is active low
    assign mrsActive = !pinSync[4];
    // pins moved outside master reset wait here until the next one
    assign cfgPins   = fbwrm_pkg::fbwrm_cfg_s'(pinSync[3:0]);

    // ******************************************************************
    // half-word queue
    // ******************************************************************
    logic [fbwrm_pkg::HALF_W-1:0] mem      [DEPTH];
    logic [fbwrm_pkg::HALF_W-1:0] next_mem [DEPTH];
    logic [PW-1:0]                wrPtr, next_wrPtr;
    logic [PW-1:0]                rdPtr, next_rdPtr;
    logic [CW-1:0]                count, next_count;
    fbwrm_pkg::fbwrm_cfg_s        cfg, next_cfg;
    fbwrm_pkg::fbwrm_words_s      next_rdWords;
    logic                         next_rdValid;
    logic [fbwrm_pkg::HALF_W-1:0] halves   [fbwrm_pkg::MAX_HALVES];
    logic [2:0]                   pushN, needN;
    logic                         doPush, outLoad;
    logic [CW-1:0]                freeCnt;

    always_comb begin
        if (cfg.inNarrow) begin
            halves[0] = wrWords.word0[fbwrm_pkg::HALF_W-1:0];
            halves[1] = wrWords.word1[fbwrm_pkg::HALF_W-1:0];
            halves[2] = '0;
            halves[3] = '0;
        end else begin
            halves[0] = wrWords.word0[fbwrm_pkg::WORD_W-1:fbwrm_pkg::HALF_W];
            halves[1] = wrWords.word0[fbwrm_pkg::HALF_W-1:0];
            halves[2] = wrWords.word1[fbwrm_pkg::WORD_W-1:fbwrm_pkg::HALF_W];
            halves[3] = wrWords.word1[fbwrm_pkg::HALF_W-1:0];
        end
        case ({cfg.wrDouble, cfg.inNarrow})
            2'b01:   pushN = 3'd1;
            2'b11:   pushN = 3'd2;
            2'b10:   pushN = 3'd4;
            default: pushN = 3'd2;
        endcase
        case ({cfg.rdDouble, cfg.outNarrow})
            2'b01:   needN = 3'd1;
            2'b11:   needN = 3'd2;
            2'b10:   needN = 3'd4;
            default: needN = 3'd2;
        endcase
        freeCnt = CW'(DEPTH) - count;
        // a write is all or nothing: every slot of the cycle needs room
        wrReady = clkEn && !mrsActive && (freeCnt >= CW'(pushN));
        doPush  = wrValid && wrReady;
        // output stage reloads when empty or being taken
        outLoad = !mrsActive && (!rdValid || rdReady) && (count >= CW'(needN));

        next_mem = mem;
        for (int i = 0; i < fbwrm_pkg::MAX_HALVES; i++) begin
            if (doPush && i < int'(pushN))
                next_mem[wrPtr + PW'(i)] = halves[i];
        end

        // word1 stays zero on a single-rate read port
        next_rdWords = rdWords;
        if (outLoad) begin
            if (cfg.outNarrow) begin
                next_rdWords.word0 = {10'h000, mem[rdPtr]};
                next_rdWords.word1 = cfg.rdDouble ? {10'h000, mem[rdPtr + PW'(1)]} : 20'h00000;
            end else begin
                next_rdWords.word0 = {mem[rdPtr], mem[rdPtr + PW'(1)]};
                next_rdWords.word1 = cfg.rdDouble ?
                    {mem[rdPtr + PW'(2)], mem[rdPtr + PW'(3)]} : 20'h00000;
            end
        end
        next_rdValid = outLoad ? 1'b1 : (rdReady ? 1'b0 : rdValid);

        next_wrPtr = wrPtr + (doPush ? PW'(pushN) : PW'(0));
        next_rdPtr = rdPtr + (outLoad ? PW'(needN) : PW'(0));
        next_count = count + (doPush ? CW'(pushN) : CW'(0)) - (outLoad ? CW'(needN) : CW'(0));
        next_cfg   = cfg;

        // config taken only in master reset
        if (mrsActive) begin
            next_cfg     = cfgPins;
            next_wrPtr   = '0;
            next_rdPtr   = '0;
            next_count   = '0;
            next_rdValid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            count   <= '0;
            cfg     <= '0;
            rdValid <= 1'b0;
            rdWords <= '0;
        end else if (clkEn) begin
            wrPtr   <= next_wrPtr;
            rdPtr   <= next_rdPtr;
            count   <= next_count;
            cfg     <= next_cfg;
            rdValid <= next_rdValid;
            rdWords <= next_rdWords;
        end
    end

    // storage has no reset; pointers guard its contents
    always_ff @(posedge clk) begin
        if (clkEn)
            mem <= next_mem;
    end

    // ******************************************************************
    // flags and events
    // ******************************************************************
    fbwrm_pkg::fbwrm_flags_s flags, next_flags;
    logic [7:0]              aeThresh, afThresh;
    logic [fbwrm_pkg::EV_W-1:0] events;

    always_comb begin
        // flags come from next values so they move together with count
        // empty judged on whole read units after write
        next_flags.empty       = next_count < CW'(needN);
        // compared as ints so thresholds above the depth are not cut short
        next_flags.almostEmpty = int'(next_count) <= int'(aeThresh);
        // full judged on whole write units after read
        next_flags.full        = (CW'(DEPTH) - next_count) < CW'(pushN);
        next_flags.almostFull  = int'(next_count) + int'(afThresh) >= DEPTH;
        events = '0;
        events[fbwrm_pkg::EV_FULL]        = next_flags.full && !flags.full;
        events[fbwrm_pkg::EV_EMPTY]       = next_flags.empty && !flags.empty;
        // refusals while master reset is held are expected and not reported
        events[fbwrm_pkg::EV_REFUSED]     = wrValid && !wrReady && clkEn && !mrsActive;
        events[fbwrm_pkg::EV_ALMOST_FULL] = next_flags.almostFull && !flags.almostFull;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            flags <= 4'h1;
        else if (clkEn)
            flags <= next_flags;
    end

    assign emptyFlagOut    = flags.empty;
    assign almostEmptyFlag = flags.almostEmpty;
    assign fullFlagOut     = flags.full;
    assign almostFullFlag  = flags.almostFull;

    // ******************************************************************
    // apb slave
    // ******************************************************************
    function automatic fbwrm_pkg::fbwrm_reg_e decodeAddr(input logic [11:0] a);
        if (a == fbwrm_pkg::OFF_STATUS)
            return fbwrm_pkg::REG_STAT;
        else if (a == fbwrm_pkg::OFF_MASK)
            return fbwrm_pkg::REG_MASK;
        else if (a == fbwrm_pkg::OFF_THRESH)
            return fbwrm_pkg::REG_THR;
        else if (a == fbwrm_pkg::OFF_LEVEL)
            return fbwrm_pkg::REG_LVL;
        else
            return fbwrm_pkg::REG_NONE;
    endfunction : decodeAddr

    logic [fbwrm_pkg::EV_W-1:0] status, next_status;
    logic [fbwrm_pkg::EV_W-1:0] mask, next_mask;
    logic [7:0]                 next_aeThresh, next_afThresh;
    logic [31:0]                next_prdata;
    logic [31:0]                levelWord;
    logic                       next_irq;
    fbwrm_pkg::fbwrm_reg_e      regSel;
    logic                       access, setup;

    always_comb begin
        regSel  = decodeAddr(paddr);
        setup   = psel && !penable;
        access  = psel && penable && clkEn;
        pready  = psel && penable && clkEn;
        // unmapped reads give zero and unmapped writes are dropped
        pslverr = pready && (regSel == fbwrm_pkg::REG_NONE);

        // level word: count at the bottom, flags and setup above it
        levelWord                               = 32'h00000000;
        levelWord[CW-1:0]                       = count;
        levelWord[fbwrm_pkg::LV_FLAGS_LSB +: 4] = flags;
        levelWord[fbwrm_pkg::LV_CFG_LSB +: 4]   = cfg;

        // read data is captured in the setup cycle and held through access
        next_prdata = prdata;
        if (setup) begin
            case (regSel)
                fbwrm_pkg::REG_STAT: next_prdata = {28'h0000000, status};
                fbwrm_pkg::REG_MASK: next_prdata = {28'h0000000, mask};
                fbwrm_pkg::REG_THR:  next_prdata = {16'h0000, afThresh, aeThresh};
                fbwrm_pkg::REG_LVL:  next_prdata = levelWord;
                default:             next_prdata = 32'h00000000;
            endcase
        end

        next_mask     = mask;
        next_aeThresh = aeThresh;
        next_afThresh = afThresh;
        next_status   = status;
        if (access && pwrite) begin
            if (regSel == fbwrm_pkg::REG_MASK)
                next_mask = pwdata[fbwrm_pkg::EV_W-1:0];
            else if (regSel == fbwrm_pkg::REG_THR) begin
                next_aeThresh = pwdata[fbwrm_pkg::TH_AE_LSB +: fbwrm_pkg::TH_W];
                next_afThresh = pwdata[fbwrm_pkg::TH_AF_LSB +: fbwrm_pkg::TH_W];
            end
        end
        // only bits that were reported get cleared; a new event wins
        if (access && !pwrite && regSel == fbwrm_pkg::REG_STAT)
            next_status = status & ~prdata[fbwrm_pkg::EV_W-1:0];
        next_status = next_status | events;

        // irq follows the same next values that status and mask take
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status   <= '0;
            mask     <= fbwrm_pkg::MASK_RESET;
            aeThresh <= fbwrm_pkg::AE_RESET;
            afThresh <= fbwrm_pkg::AF_RESET;
            prdata   <= 32'h00000000;
            irq      <= 1'b0;
        end else if (clkEn) begin
            status   <= next_status;
            mask     <= next_mask;
            aeThresh <= next_aeThresh;
            afThresh <= next_afThresh;
            prdata   <= next_prdata;
            irq      <= next_irq;
        end
    end
endmodule : fbwrm_rate_matcher
`default_nettype wire

// ---- testbench/fbwrm_rate_matcher_properties.sv ----
// port properties of the rate matcher
// assumes one clock; bound into the matcher from the bench top
`default_nettype none
module fbwrm_rate_matcher_properties (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    clkEn,
    input wire logic                    masterResetIn,
    input wire logic                    readRateSelect,
    input wire logic                    outputWidthSelect,
    input wire logic                    wrReady,
    input wire logic                    rdValid,
    input wire logic                    rdReady,
    input wire fbwrm_pkg::fbwrm_words_s rdWords,
    input wire logic                    emptyFlagOut,
    input wire logic                    irq,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic [11:0]             paddr,
    input wire logic                    pready,
    input wire logic                    pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************
    // data port
    // ****************
    property p_rstVal;
        $rose(rst_n) |-> !rdValid && emptyFlagOut && !irq;
    endproperty
    a_rstVal: assert property (p_rstVal) else $error("bad outputs after reset");
    // pin sampled high in this cycle only; through the synchroniser lag a low pin two cycles back can still clear the unit
    property p_hold;
        rdValid && !rdReady && masterResetIn |=> rdValid && $stable(rdWords);
    endproperty
    a_hold: assert property (p_hold) else $error("unit dropped before taken");
    property p_narrow;
        rdValid && outputWidthSelect |-> rdWords.word0[19:10] == 0 && rdWords.word1[19:10] == 0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow upper bits set");
    property p_sdrOut;
        rdValid && !readRateSelect |-> rdWords.word1 == 0;
    endproperty
    a_sdrOut: assert property (p_sdrOut) else $error("falling slot used");
    property p_mrs;
        !masterResetIn [*5] |-> !wrReady && !rdValid;
    endproperty
    a_mrs: assert property (p_mrs) else $error("traffic in master reset");
    // ****************
    // register bus
    // ****************
    property p_freeze;
        !clkEn |-> !wrReady && !pready;
    endproperty
    a_freeze: assert property (p_freeze) else $error("ready while frozen");
    property p_ready;
        psel && penable && clkEn |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb wait state");
    property p_err;
        psel && penable && clkEn && paddr > 12'h00C |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped without error");
endmodule : fbwrm_rate_matcher_properties
`default_nettype wire

// ---- testbench/fbwrm_rate_matcher_tb_top.sv ----
// bench: random words through all sixteen port setups, apb and irq
// assumes the reader partner and the checker are compiled first
`default_nettype none
module fbwrm_rate_matcher_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, clkEn = 1, mrsIn = 0, wrValid = 0, stall = 0, slow = 0;
    logic wrReady, rdValid, rdReady, eF, aeF, fF, afF, irq, took, perr;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [63:0] r;
    int err_count = 0, check_count = 0, n;
    fbwrm_pkg::fbwrm_cfg_s   pins = '0;
    fbwrm_pkg::fbwrm_words_s wrWords = '0, rdWords, e;
    fbwrm_pkg::fbwrm_words_s expQ[$];
    logic [9:0]              hq[$];

    always #4 clk = ~clk;

    fbwrm_rate_matcher dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .masterResetIn(mrsIn),
        .writeRateSelect(pins.wrDouble), .readRateSelect(pins.rdDouble),
        .inputWidthSelect(pins.inNarrow), .outputWidthSelect(pins.outNarrow),
        .wrValid(wrValid), .wrReady(wrReady), .wrWords(wrWords), .rdValid(rdValid),
        .rdReady(rdReady), .rdWords(rdWords), .emptyFlagOut(eF), .almostEmptyFlag(aeF),
        .fullFlagOut(fF), .almostFullFlag(afF), .irq(irq), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    fbwrm_reader u_reader (.clk(clk), .stall(stall), .slow(slow), .rdReady(rdReady));

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // starts right after an edge; holds the request until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // pins move only while held in master reset
    task automatic mr(input fbwrm_pkg::fbwrm_cfg_s c);
        mrsIn <= 1'b0;
        repeat (3) @(posedge clk);
        pins <= c;
        wrValid <= 1'b1;
        @(posedge clk) wrValid <= 1'b0;
        repeat (3) @(posedge clk);
        mrsIn <= 1'b1;
        hq.delete();
        repeat (4) @(posedge clk);
    endtask : mr

    // write one unit; notes the halves and the read units they complete
    task automatic put(input fbwrm_pkg::fbwrm_words_s w);
        fbwrm_pkg::fbwrm_words_s u;
        int need, k;
        wrValid <= 1'b1; wrWords <= w;
        @(negedge clk);
        for (int t = 0; t < 8 && wrReady !== 1'b1; t++) @(negedge clk);
        took = wrReady === 1'b1;
        if (!took) return;
        @(posedge clk);
        if (pins.inNarrow) begin
            hq.push_back(w.word0[9:0]);
            if (pins.wrDouble) hq.push_back(w.word1[9:0]);
        end else begin
            hq.push_back(w.word0[19:10]); hq.push_back(w.word0[9:0]);
            if (pins.wrDouble) begin
                hq.push_back(w.word1[19:10]); hq.push_back(w.word1[9:0]);
            end
        end
        k = pins.outNarrow ? 1 : 2;
        need = k * (pins.rdDouble ? 2 : 1);
        while (hq.size() >= need) begin
            u.word0 = k == 1 ? {10'h000, hq[0]} : {hq[0], hq[1]};
            u.word1 = !pins.rdDouble ? 20'h00000 : (k == 1 ? {10'h000, hq[1]} : {hq[2], hq[3]});
            expQ.push_back(u);
            repeat (need) void'(hq.pop_front());
        end
    endtask : put

    task automatic drain;
        wrValid <= 1'b0;
        for (int t = 0; t < 400 && expQ.size() > 0; t++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : drain

    always @(posedge clk) begin
        if (rst_n && rdValid === 1'b1 && rdReady === 1'b1) begin
            if (expQ.size() == 0) check(rdWords, 'x, "extra unit");
            else begin
                e = expQ.pop_front();
                check(rdWords.word0, e.word0, "word0");
                check(rdWords.word1, e.word1, "word1");
            end
        end
    end

    initial begin
        #200000;
        err_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h3DB29D26));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        mr(4'h0);
        apb(1'b0, fbwrm_pkg::OFF_MASK, 0);
        check(rd, {28'h0, fbwrm_pkg::MASK_RESET}, "mask");
        apb(1'b0, fbwrm_pkg::OFF_THRESH, 0);
        check(rd, {16'h0, fbwrm_pkg::AF_RESET, fbwrm_pkg::AE_RESET}, "thresh");
        apb(1'b0, 12'h010, 32'hFFFFFFFF);
        check({perr, rd}, {1'b1, 32'h0}, "unmapped");
        check(irq, 1'b0, "irq masked");
        @(posedge clk) clkEn <= 1'b0;
        repeat (2) @(posedge clk);
        clkEn <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            mr(c[3:0]);
            slow <= c[0];
            for (int i = 0; i < 8; i++) begin
                r = {$urandom, $urandom};
                put(r[39:0]);
            end
            drain();
            apb(1'b0, fbwrm_pkg::OFF_LEVEL, 0);
            check(rd[23:16], {c[3:0], 4'h3}, "level flags");
            check(rd[8:0], 9'h000, "level count");
        end
        // fill with the reader stalled: queue plus the parked output unit
        mr(4'h3);
        stall <= 1'b1;
        n = 0;
        do begin
            r = {$urandom, $urandom};
            put(r[39:0]);
            n += took;
        end while (took && n < 40);
        check(n, 33, "fill count");
        check(fF, 1'b1, "full flag");
        check({afF, eF, aeF}, 3'b100, "flags when full");
        @(posedge clk) stall <= 1'b0;
        drain();
        check(expQ.size(), 0, "drained");
        check({eF, aeF, fF, afF}, 4'b1100, "flags drained");
        // the write refused at the full queue is pending; unmask it
        apb(1'b1, fbwrm_pkg::OFF_MASK, 32'h4);
        repeat (2) @(negedge clk);
        check(irq, 1'b1, "irq raised");
        apb(1'b0, fbwrm_pkg::OFF_STATUS, 0);
        check(rd[2], 1'b1, "status refused");
        repeat (3) @(negedge clk);
        check(irq, 1'b0, "irq cleared");
        give_verdict();
    end
endmodule : fbwrm_rate_matcher_tb_top

bind fbwrm_rate_matcher fbwrm_rate_matcher_properties u_props (.clk(clk), .rst_n(rst_n),
    .clkEn(clkEn), .masterResetIn(masterResetIn), .readRateSelect(readRateSelect),
    .outputWidthSelect(outputWidthSelect), .wrReady(wrReady), .rdValid(rdValid),
    .rdReady(rdReady), .rdWords(rdWords), .emptyFlagOut(emptyFlagOut), .irq(irq),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- testbench/fbwrm_reader.sv ----
// reader partner: takes units promptly or with random stalls
// assumes the bench seeds the random generator once
`default_nettype none
module fbwrm_reader (
    input  wire logic clk,
    input  wire logic stall,
    input  wire logic slow,
    output var logic  rdReady
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rdReady = 1'b0;
    // a stalled reader leaves the unit parked in the output stage
    always @(posedge clk) begin
        rdReady <= !stall && (!slow || $urandom_range(1) == 1);
    end
endmodule : fbwrm_reader
`default_nettype wire
